// >>> src/sigi_top.sv
// Six-group digital I/O with shared IRQ line interrupt logic
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sigi_defs.svh"
module sigi_top #(
  parameter int NUM_GROUPS = `SIGI_NUM_GROUPS,
  parameter int LOW_CYCLES = `SIGI_LOW_CYCLES
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Register port
  input  wire sigi_pkg::sigi_addr_t addr,
  input  wire sigi_pkg::sigi_data_t wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output sigi_pkg::sigi_data_t  rdata,
  // I/O lines, 24 per group
  input  wire logic [143:0]     io_in,
  output logic      [143:0]     io_out,
  output logic      [143:0]     io_oe,
  // Shared IRQ line
  input  wire logic             irq_in,
  output logic                  irq_out,
  output logic                  irq_oe
);
  import sigi_pkg::*;

  localparam int LPG = `SIGI_LINES_PER_GRP;

  // Elaboration checks on the parameters
  if (NUM_GROUPS != `SIGI_NUM_GROUPS) begin : g_bad_groups
    $error("sigi_top: NUM_GROUPS must match the six-group map");
  end
  if (LOW_CYCLES < `SIGI_LOW_CYCLES || LOW_CYCLES > 255) begin : g_bad_low
    $error("sigi_top: LOW_CYCLES below minimum or too large");
  end

  // Per-group read data, flags and edge history
  logic [7:0]            rd_grp [NUM_GROUPS];
  logic [NUM_GROUPS-1:0] user_prev_q;
  logic [NUM_GROUPS-1:0] user_now;
  logic [NUM_GROUPS-1:0] event_w;
  logic [NUM_GROUPS-1:0] flag_q;
  logic [NUM_GROUPS-1:0] pend_q;

  // Card-level decode
  wire logic                  hit_ack;
  wire logic                  hit_status;
  wire logic [2:0]            grp_sel;
  wire logic [1:0]            sec_sel;
  wire logic                  pulse_busy;
  wire logic                  pulse_start;
  wire logic [7:0]            status_w;
  wire logic [NUM_GROUPS-1:0] ack_mask;
  wire logic [NUM_GROUPS-1:0] flag_d;
  wire logic [NUM_GROUPS-1:0] pend_d;
  logic      [7:0]            rd_d;

  assign grp_sel    = addr[4:2];
  assign sec_sel    = addr[1:0];
  assign hit_ack    = wr && (addr == `SIGI_ADDR_ACK);
  assign hit_status = (addr == `SIGI_ADDR_STATUS);
  // RULE3: source flags readable by host
  assign status_w   = {|flag_q, irq_in, flag_q};

  // RULE6: identical logic for every group
  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g = g + 1) begin : grp
      // Group storage, kept local so each register has one writer
      logic [7:0]          lat_a_q;
      logic [7:0]          lat_b_q;
      logic [7:0]          lat_c_q;
      logic [3:0]          dir_q;
      logic [LPG-1:0]      out_q;
      logic [LPG-1:0]      oe_q;
      wire logic           hit;
      wire logic           wr_a;
      wire logic           wr_b;
      wire logic           wr_c;
      wire logic           wr_dir;
      wire logic [7:0]     pin_a;
      wire logic [7:0]     pin_b;
      wire logic [7:0]     pin_c;
      wire logic [7:0]     in_c;
      wire logic [3:0]     dir;
      wire logic           rise;
      wire logic           armed;
      wire logic [LPG-1:0] oe_d;

      // Section write decode
      assign dir    = dir_q;
      assign hit    = (grp_sel == 3'(g));
      assign wr_a   = wr && hit && (sec_sel == `SIGI_OFF_PORT_A);
      assign wr_b   = wr && hit && (sec_sel == `SIGI_OFF_PORT_B);
      assign wr_c   = wr && hit && (sec_sel == `SIGI_OFF_PORT_C);
      assign wr_dir = wr && hit && (sec_sel == `SIGI_OFF_DIR);

      // RULE7: sections read pin or latch by direction
      assign in_c  = io_in[g*LPG+16 +: 8];
      assign pin_a = dir[`SIGI_DIR_A] ? io_in[g*LPG +: 8] : lat_a_q;
      assign pin_b = dir[`SIGI_DIR_B] ? io_in[g*LPG+8 +: 8] : lat_b_q;
      assign pin_c = {dir[`SIGI_DIR_CHI] ? in_c[7:4] : lat_c_q[7:4],
                      dir[`SIGI_DIR_CLO] ? in_c[3:0] : lat_c_q[3:0]};
      assign rd_grp[g] = (sec_sel == `SIGI_OFF_PORT_A) ? pin_a :
                         (sec_sel == `SIGI_OFF_PORT_B) ? pin_b :
                         (sec_sel == `SIGI_OFF_PORT_C) ? pin_c :
                         {4'h0, dir};

      // RULE4: rising edge on user line requests
      assign user_now[g] = pin_c[`SIGI_USER_IRQ_BIT];
      assign rise        = user_now[g] && !user_prev_q[g];
      // RULE5: bit 7 gates the request; RULE8: held off while flagged
      assign armed       = pin_c[`SIGI_IRQ_EN_BIT] && !flag_q[g];
      assign event_w[g]  = rise && armed;

      // Port A latch
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          lat_a_q <= 8'h00;
        end else if (wr_a) begin
          lat_a_q <= wdata;
        end
      end

      // Port B latch
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          lat_b_q <= 8'h00;
        end else if (wr_b) begin
          lat_b_q <= wdata;
        end
      end

      // Port C latch, also the enable source when C hi drives
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          lat_c_q <= 8'h00;
        end else if (wr_c) begin
          lat_c_q <= wdata;
        end
      end

      // Direction register, all inputs out of reset
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          dir_q <= `SIGI_DIR_RESET;
        end else if (wr_dir) begin
          dir_q <= wdata[3:0];
        end
      end

      // RULE7: output enable per section
      assign oe_d = {{4{~dir[`SIGI_DIR_CHI]}}, {4{~dir[`SIGI_DIR_CLO]}},
                     {8{~dir[`SIGI_DIR_B]}}, {8{~dir[`SIGI_DIR_A]}}};

      // Pin drive registers
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          out_q <= 24'h000000;
          oe_q  <= 24'h000000;
        end else begin
          out_q <= {lat_c_q, lat_b_q, lat_a_q};
          oe_q  <= oe_d;
        end
      end

      // Registered drive onto this group's slice of the pins
      assign io_out[g*LPG +: LPG] = out_q;
      assign io_oe[g*LPG +: LPG]  = oe_q;
    end
  endgenerate

  assign pulse_start = (|pend_q) && !pulse_busy;

  // RULE8: ack clears, new event wins
  assign ack_mask = hit_ack ? wdata[NUM_GROUPS-1:0] : {NUM_GROUPS{1'b0}};
  assign flag_d   = event_w | (flag_q & ~ack_mask);
  assign pend_d   = event_w | (pulse_start ? {NUM_GROUPS{1'b0}} : pend_q);

  // Flags, pending requests and edge history
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      user_prev_q <= '0;
      flag_q      <= '0;
      pend_q      <= '0;
    end else begin
      user_prev_q <= user_now;
      flag_q      <= flag_d;
      pend_q      <= pend_d;
    end
  end

  // Read data select
  always_comb begin
    rd_d = 8'h00;
    if (hit_status) begin
      rd_d = status_w;
    end else if (grp_sel < 3'(NUM_GROUPS)) begin
      rd_d = rd_grp[grp_sel];
    end
  end

  // Read data register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rd_d : 8'h00;
    end
  end

  // RULE1: line driven only during the pulse
  sigi_pulse #(
    .LOW_CYCLES (LOW_CYCLES)
  ) u_pulse (
    .clock   (clock),
    .rst_n   (rst_n),
    .start   (pulse_start),
    .busy    (pulse_busy),
    .irq_out (irq_out),
    .irq_oe  (irq_oe)
  );
endmodule
`default_nettype wire

// >>> src/sigi_defs.svh
// Constants for the shared IRQ group interrupt block
// Function
// RULE1: IRQ output stays high impedance when idle
// RULE2: Drive low 500 ns, rising edge, release
// RULE3: Host-readable flag marks this card as source
// RULE4: Group port C bit 3 requests interrupt
// RULE5: Port C bit 7 is I/O and enable
// RULE6: Six identical 24-line groups with own logic
// RULE7: Four and eight bit sections select direction
// RULE8: Host acknowledges flag; no repeat until cleared
`ifndef SIGI_DEFS_SVH
`define SIGI_DEFS_SVH

`define SIGI_NUM_GROUPS     6
`define SIGI_LINES_PER_GRP  24
`define SIGI_ADDR_W         5
`define SIGI_DATA_W         8

// Register map: group g at g*4 + section, then card registers
`define SIGI_OFF_PORT_A     2'h0
`define SIGI_OFF_PORT_B     2'h1
`define SIGI_OFF_PORT_C     2'h2
`define SIGI_OFF_DIR        2'h3
`define SIGI_ADDR_STATUS    5'h18
`define SIGI_ADDR_ACK       5'h19

// Direction register bits, 1 selects input
`define SIGI_DIR_A          0
`define SIGI_DIR_B          1
`define SIGI_DIR_CLO        2
`define SIGI_DIR_CHI        3
`define SIGI_DIR_RESET      4'hf

// Port C bits with interrupt duties
`define SIGI_USER_IRQ_BIT   3
`define SIGI_IRQ_EN_BIT     7

// Status register bits
`define SIGI_STAT_LINE      6
`define SIGI_STAT_CARD      7

// Interrupt pulse timing
`define SIGI_CLK_NS         50
`define SIGI_LOW_NS         500
`define SIGI_LOW_CYCLES     ((`SIGI_LOW_NS + `SIGI_CLK_NS - 1) / `SIGI_CLK_NS)

`endif

// >>> src/sigi_pkg.sv
// Types for the shared IRQ group interrupt block
package sigi_pkg;
  typedef enum logic [1:0] {
    SIGI_IDLE,
    SIGI_DRIVE_LOW,
    SIGI_DRIVE_HIGH
  } sigi_pulse_state_t;

  typedef logic [4:0] sigi_addr_t;
  typedef logic [7:0] sigi_data_t;
endpackage

// >>> src/sigi_pulse.sv
// Shared IRQ line pulse shaper
`timescale 1ns/1ps
`default_nettype none
`include "sigi_defs.svh"
module sigi_pulse #(
  parameter int LOW_CYCLES = `SIGI_LOW_CYCLES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Request side
  input  wire logic start,
  output logic      busy,
  // Open-drain style IRQ line
  output logic      irq_out,
  output logic      irq_oe
);
  import sigi_pkg::*;

  // Elaboration check on the low-phase count
  if (LOW_CYCLES < 1 || LOW_CYCLES > 255) begin : g_bad_low
    $error("sigi_pulse: LOW_CYCLES out of range");
  end

  sigi_pulse_state_t state_q;
  sigi_pulse_state_t state_d;
  logic [7:0]        cnt_q;
  logic [7:0]        cnt_d;
  logic              out_d;
  logic              oe_d;
  wire logic         low_done;

  assign low_done = (cnt_q == 8'(LOW_CYCLES - 1));
  assign busy     = (state_q != SIGI_IDLE);

  // Next state, count and pin drive
  always_comb begin
    state_d = state_q;
    cnt_d   = 8'h00;
    out_d   = 1'b1;
    oe_d    = 1'b0;
    case (state_q)
      SIGI_IDLE: begin
        if (start) begin
          state_d = SIGI_DRIVE_LOW;
          out_d   = 1'b0;
          oe_d    = 1'b1;
        end
      end
      // RULE2: low for full count
      SIGI_DRIVE_LOW: begin
        out_d = 1'b0;
        oe_d  = 1'b1;
        cnt_d = cnt_q + 8'h01;
        if (low_done) begin
          state_d = SIGI_DRIVE_HIGH;
          out_d   = 1'b1;
        end
      end
      // RULE2: one high cycle, then release
      SIGI_DRIVE_HIGH: begin
        state_d = SIGI_IDLE;
      end
      default: begin
        state_d = SIGI_IDLE;
      end
    endcase
  end

  // State and pin registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SIGI_IDLE;
      cnt_q   <= 8'h00;
      irq_out <= 1'b1;
      // RULE1: released from reset
      irq_oe  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      irq_out <= out_d;
      irq_oe  <= oe_d;
    end
  end
endmodule
`default_nettype wire

// >>> bench/sigi_host_model.sv
// Host side of the shared IRQ wire: pull-up and pulse counter
`timescale 1ns/1ps
`default_nettype none
module sigi_host_model (
  // Clock
  input  wire logic clock,
  // Card drive onto the shared wire
  input  wire logic irq_out,
  input  wire logic irq_oe,
  // Wire level and pulse tallies
  output logic      irq_wire,
  output int        pulses,
  output int        shorts
);
  int low_n   = 0;
  int pulse_n = 0;
  int short_n = 0;
  assign irq_wire = irq_oe ? irq_out : 1'b1;
  assign pulses   = pulse_n;
  assign shorts   = short_n;
  // low width judged at rising edge
  always @(posedge clock) begin
    if (!irq_wire) begin
      low_n++;
    end else if (low_n > 0) begin
      if (low_n * 50 >= 500) pulse_n++;
      else short_n++;
      low_n = 0;
    end
  end
endmodule
`default_nettype wire

// >>> bench/sigi_chk.sv
// Port checker for the shared IRQ group block
`timescale 1ns/1ps
`default_nettype none
`include "sigi_defs.svh"
module sigi_chk #(
  parameter int LOW_CYCLES = 10
) (
  // Clock and reset
  input wire logic                 clock,
  input wire logic                 rst_n,
  // Register port
  input wire sigi_pkg::sigi_addr_t addr,
  input wire sigi_pkg::sigi_data_t wdata,
  input wire logic                 wr,
  input wire logic                 rd,
  input wire sigi_pkg::sigi_data_t rdata,
  // Lines and IRQ
  input wire logic [143:0]         io_in,
  input wire logic [143:0]         io_out,
  input wire logic [143:0]         io_oe,
  input wire logic                 irq_in,
  input wire logic                 irq_out,
  input wire logic                 irq_oe
);
  import sigi_pkg::*;
  logic [7:0] low_q;
  logic       stat_rd_q;
  wire logic  dir_wr = wr && (addr == 5'h0b);
  // Counts cycles of the driven-low phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) low_q <= 8'h00;
    else low_q <= (irq_oe && !irq_out) ? low_q + 8'h01 : 8'h00;
  end
  // Marks the cycle in which status read data stand
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) stat_rd_q <= 1'b0;
    else stat_rd_q <= rd && (addr == `SIGI_ADDR_STATUS);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_IDLE_HIGH: assert property (!irq_oe |-> irq_out)
    else $error("irq drive not idle high");
  AST_LOW_WIDTH: assert property (irq_oe && irq_out |-> low_q == 8'(LOW_CYCLES))
    else $error("low phase length wrong");
  AST_RELEASE: assert property (irq_oe && irq_out |=> !irq_oe)
    else $error("line not released after edge");
  AST_START_LOW: assert property ($rose(irq_oe) |-> !irq_out)
    else $error("pulse did not start low");
  AST_CARD_FLAG: assert property (stat_rd_q |-> rdata[7] == |rdata[5:0])
    else $error("card flag not OR of group flags");
  AST_LINE_BIT: assert property (stat_rd_q |-> rdata[6] == $past(irq_in))
    else $error("status line bit wrong");
  AST_DIR_A: assert property (dir_wr |-> ##2 io_oe[55:48] == {8{!$past(wdata[0], 2)}})
    else $error("port A direction wrong");
  AST_DIR_CHI: assert property (dir_wr |-> ##2 io_oe[71:68] == {4{!$past(wdata[3], 2)}})
    else $error("port C high direction wrong");
  // Main scenarios reached
  COV_PULSE: cover property ($rose(irq_oe));
  COV_ACK: cover property (wr && addr == 5'h19);
  COV_STATUS: cover property (stat_rd_q && rdata[7]);
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the shared IRQ group block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
  import sigi_pkg::*;
  logic         clock = 1'b0;
  logic         rst_n = 1'b0;
  logic         wr = 1'b0;
  logic         rd = 1'b0;
  logic         irq_wire, irq_out, irq_oe;
  sigi_addr_t   addr = 5'h00;
  sigi_data_t   wdata = 8'h00;
  sigi_data_t   rdata;
  logic [143:0] pins_q = 144'h0;
  logic [143:0] io_in, io_out, io_oe;
  int           failures = 0;
  int           comparisons = 0;
  int           pulses, shorts;
  always #25 clock = ~clock;
  // Line level from card and outside drivers
  assign io_in = (io_oe & io_out) | (~io_oe & pins_q);
  sigi_top #(.LOW_CYCLES(10)) dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .irq_in(irq_wire), .irq_out(irq_out), .irq_oe(irq_oe));
  sigi_host_model host (.clock(clock), .irq_out(irq_out), .irq_oe(irq_oe),
    .irq_wire(irq_wire), .pulses(pulses), .shorts(shorts));
  task automatic reg_wr(input sigi_addr_t a, input sigi_data_t d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_chk(input sigi_addr_t a, input sigi_data_t e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
    @(posedge clock);
  endtask
  task automatic t_irq(input int g);
    int p0;
    p0 = pulses;
    pins_q[g*24+23] <= 1'b1;
    pins_q[g*24+19] <= 1'b1;
    repeat (25) @(posedge clock);
    `CHK(pulses, p0 + 1)
    rd_chk(5'h18, 8'hc0 | (8'h01 << g));
    pins_q[g*24+19] <= 1'b0;
    @(posedge clock);
    pins_q[g*24+19] <= 1'b1;
    repeat (25) @(posedge clock);
    `CHK(pulses, p0 + 1)
    reg_wr(5'h19, 8'h01 << g);
    rd_chk(5'h18, 8'h40);
    pins_q[g*24+19] <= 1'b0;
  endtask
  task automatic t_disabled();
    int p0;
    p0 = pulses;
    pins_q[23] <= 1'b0;
    @(posedge clock);
    pins_q[19] <= 1'b1;
    repeat (25) @(posedge clock);
    `CHK(pulses, p0)
    rd_chk(5'h18, 8'h40);
    pins_q[19] <= 1'b0;
  endtask
  task automatic t_dir();
    pins_q[55:48] <= 8'h3c;
    reg_wr(5'h0b, 8'h05);
    reg_wr(5'h09, 8'ha5);
    #1 `CHK(io_oe[71:48], 24'hf0ff00)
    `CHK(io_out[63:56], 8'ha5)
    @(posedge clock);
    rd_chk(5'h08, 8'h3c);
    rd_chk(5'h09, 8'ha5);
    rd_chk(5'h1a, 8'h00);
  endtask
  task automatic t_latch();
    int p0;
    p0 = pulses;
    reg_wr(5'h0a, 8'h80);
    #1 `CHK(io_out[71], 1'b1)
    @(posedge clock);
    pins_q[67] <= 1'b1;
    repeat (4) @(posedge clock);
    rd_chk(5'h18, 8'h84);
    repeat (25) @(posedge clock);
    `CHK(pulses, p0 + 1)
    rd_chk(5'h18, 8'hc4);
  endtask
  task automatic test_done();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1 `CHK(io_oe, 144'h0)
    `CHK(irq_oe, 1'b0)
    @(posedge clock);
    rd_chk(5'h0b, 8'h0f);
    for (int g = 0; g < 6; g++) t_irq(g);
    t_disabled();
    t_dir();
    t_latch();
    `CHK(shorts, 0)
    test_done();
  end
  // Cuts a hang short
  initial begin
    repeat (2000) @(posedge clock);
    failures++;
    test_done();
  end
endmodule
bind sigi_top sigi_chk #(.LOW_CYCLES(LOW_CYCLES)) u_chk (.clock(clock), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .io_in(io_in),
  .io_out(io_out), .io_oe(io_oe), .irq_in(irq_in), .irq_out(irq_out), .irq_oe(irq_oe));
`default_nettype wire
